//--- rcv_defines.vh
// Purpose: constants for the calendar value window
// Assumes: included by bare name
// Notes: offsets, fields, resets and page codes
`ifndef RCV_DEFINES_VH
`define RCV_DEFINES_VH
`define RCV_ADDR_W 2
`define RCV_OFF_WINDOW 2'h0
`define RCV_OFF_CTRL 2'h1
`define RCV_CTRL_PTR_LSB 8
`define RCV_CTRL_UNLOCK_BIT 0
`define RCV_PAGE_MINSEC 2'h0
`define RCV_PAGE_WDHR 2'h1
`define RCV_PAGE_MTHDAY 2'h2
`define RCV_PAGE_YEAR 2'h3
`define RCV_PTR_RST 2'h0
`define RCV_UNLOCK_RST 1'h0
`define RCV_YEAR_TEN_MSB 7
`define RCV_YEAR_TEN_LSB 4
`define RCV_MTH_TEN_BIT 12
`define RCV_MTH_ONE_MSB 11
`define RCV_MTH_ONE_LSB 8
`define RCV_DAY_TEN_MSB 5
`define RCV_DAY_TEN_LSB 4
`define RCV_WEEKDAY_FIELD_MSB 10
`define RCV_WEEKDAY_FIELD_LSB 8
`define RCV_HR_TEN_MSB 5
`define RCV_HR_TEN_LSB 4
`define RCV_ONE_MSB 3
`define RCV_ONE_LSB 0
`endif

//--- rcv_page_mem.v
// Purpose: four 16-bit storage pages of the calendar value window
// Assumes: one write port, registered read data
// Notes: read data reflects the page selected last cycle
`timescale 1ns/10ps
module rcv_page_mem (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire wr_en,
  input wire [1:0] wr_page,
  input wire [15:0] wr_data,
  input wire [1:0] rd_page,
  output reg [15:0] rd_data
);
  reg [15:0] mem_r [0:3];
  integer i;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_r[i] <= 16'h0000;
      end
      rd_data <= 16'h0000;
    end else if (ce) begin
      if (wr_en) begin
        mem_r[wr_page] <= wr_data;
      end
      rd_data <= mem_r[rd_page];
    end
  end
endmodule // rcv_page_mem

//--- rcv_value_window.v
// What this block does
// - pointer 11 shows year, 10 month and day, 01 weekday and hours.
// - year page puts tens in bits 7-4, ones in 3-0, 15-8 unused.
// - year ones digit rolls from nine to zero and carries into tens.
// - month tens is one bit at position 12 holding only 0 or 1.
// - month ones sits in bits 11-8 as a BCD value 0 to 9.
// - day tens is a 2-bit field at bits 5-4 holding 0 to 3.
// - day ones is a 4-bit field at bits 3-0 holding 0 to 9.
// - hour ones is a 4-bit field at bits 3-0 holding 0 to 9.
// - writes to value pages are ignored unless the unlock bit is 1.
// - every unimplemented bit of the value pages reads as zero.
// - pointer 00 shows minutes high byte and seconds low byte.
//
// Purpose: software window onto the BCD timekeeping pages
// Assumes: register port, read data one cycle after the read strobe
// Notes: counting of time lives elsewhere; year_step pulse advances year unless a window write comes in the same cycle
`timescale 1ns/10ps
`include "rcv_defines.vh"
module rcv_value_window (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [1:0] addr,
  input wire [15:0] wdata,
  input wire [1:0] wbe,
  input wire wr,
  input wire rd,
  input wire year_step,
  output reg [15:0] rdata,
  output reg [1:0] value_page_pointer,
  output reg calendar_write_unlock
);
  // ----------------------------------------------------------------
  // field masking and digit checks
  // ----------------------------------------------------------------
  function [3:0] bcd_digit;
    input [3:0] d;
    input [3:0] maxv;
    begin
      bcd_digit = (d > maxv) ? 4'h0 : d;
    end
  endfunction

  function [15:0] page_clean;
    input [1:0] page;
    input [15:0] v;
    reg [15:0] o;
    begin
      o = 16'h0000;
      case (page)
        `RCV_PAGE_YEAR: begin
          o[`RCV_YEAR_TEN_MSB:`RCV_YEAR_TEN_LSB] =
            bcd_digit(v[7:4], 4'h9);
          o[`RCV_ONE_MSB:`RCV_ONE_LSB] = bcd_digit(v[3:0], 4'h9);
        end
        `RCV_PAGE_MTHDAY: begin
          o[`RCV_MTH_TEN_BIT] = v[12];
          o[`RCV_MTH_ONE_MSB:`RCV_MTH_ONE_LSB] =
            bcd_digit(v[11:8], 4'h9);
          o[`RCV_DAY_TEN_MSB:`RCV_DAY_TEN_LSB] = v[5:4];
          o[`RCV_ONE_MSB:`RCV_ONE_LSB] = bcd_digit(v[3:0], 4'h9);
        end
        `RCV_PAGE_WDHR: begin
          o[`RCV_WEEKDAY_FIELD_MSB:`RCV_WEEKDAY_FIELD_LSB] =
            (v[10:8] > 3'h6) ? 3'h0 : v[10:8];
          o[`RCV_HR_TEN_MSB:`RCV_HR_TEN_LSB] =
            (v[5:4] > 2'h2) ? 2'h0 : v[5:4];
          o[`RCV_ONE_MSB:`RCV_ONE_LSB] = bcd_digit(v[3:0], 4'h9);
        end
        default: begin
          o[14:12] = (v[14:12] > 3'h5) ? 3'h0 : v[14:12];
          o[11:8] = bcd_digit(v[11:8], 4'h9);
          o[6:4] = (v[6:4] > 3'h5) ? 3'h0 : v[6:4];
          o[3:0] = bcd_digit(v[3:0], 4'h9);
        end
      endcase
      page_clean = o;
    end
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire win_wr = wr && (addr == `RCV_OFF_WINDOW);
  wire win_rd = rd && (addr == `RCV_OFF_WINDOW);
  wire ctl_wr = wr && (addr == `RCV_OFF_CTRL);
  wire ctl_rd = rd && (addr == `RCV_OFF_CTRL);
  wire upper_touch = (win_wr && wbe[1]) || win_rd;

  // ----------------------------------------------------------------
  // page storage and year counting
  // ----------------------------------------------------------------
  wire [15:0] mem_q;
  reg [15:0] cur_r;
  reg mem_we;
  reg [1:0] mem_page;
  reg [15:0] mem_wd;
  reg [7:0] yr_nxt;
  reg [15:0] merged;
  reg [1:0] ptr_nxt;
  // bypass of a write landing on the page read next, so that back-to-back
  // strobes never see the memory's stale registered read data
  reg byp_v_r;
  reg [15:0] byp_d_r;
  wire [15:0] mem_view = byp_v_r ? byp_d_r : mem_q;

  always @* begin
    merged = cur_r;
    if (wbe[1]) begin
      merged[15:8] = wdata[15:8];
    end
    if (wbe[0]) begin
      merged[7:0] = wdata[7:0];
    end
    yr_nxt = cur_r[7:0];
    if (cur_r[3:0] >= 4'h9) begin
      yr_nxt[3:0] = 4'h0;
      yr_nxt[7:4] = (cur_r[7:4] >= 4'h9) ? 4'h0 : cur_r[7:4] + 4'h1;
    end else begin
      yr_nxt[3:0] = cur_r[3:0] + 4'h1;
    end
    mem_we = 1'b0;
    mem_page = value_page_pointer;
    mem_wd = 16'h0000;
    if (win_wr && calendar_write_unlock) begin
      mem_we = 1'b1;
      mem_wd = page_clean(value_page_pointer, merged);
    end else if (year_step && !win_wr) begin
      mem_we = 1'b1;
      mem_page = `RCV_PAGE_YEAR;
      mem_wd = {8'h00, yr_nxt};
    end
  end

  // shadow of the year page, kept in step with the memory
  reg [15:0] year_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      year_r <= 16'h0000;
    end else if (ce && mem_we && mem_page == `RCV_PAGE_YEAR) begin
      year_r <= mem_wd;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byp_v_r <= 1'b0;
      byp_d_r <= 16'h0000;
    end else if (ce) begin
      byp_v_r <= mem_we && (mem_page == ptr_nxt);
      byp_d_r <= mem_wd;
    end
  end

  always @* begin
    cur_r = mem_view;
    if (year_step && !win_wr) begin
      cur_r = year_r;
    end
  end

  rcv_page_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .wr_en(mem_we),
    .wr_page(mem_page),
    .wr_data(mem_wd),
    .rd_page(ptr_nxt),
    .rd_data(mem_q)
  );

  // ----------------------------------------------------------------
  // pointer, unlock and read data
  // ----------------------------------------------------------------
  always @* begin
    ptr_nxt = value_page_pointer;
    if (ctl_wr) begin
      ptr_nxt = wdata[`RCV_CTRL_PTR_LSB+1:`RCV_CTRL_PTR_LSB];
    end else if (upper_touch &&
                 value_page_pointer != `RCV_PAGE_MINSEC) begin
      ptr_nxt = value_page_pointer - 2'h1;
    end
  end

  reg rd_win_r;
  reg rd_ctl_r;
  reg [15:0] ctl_q;
  always @* begin
    ctl_q = 16'h0000;
    ctl_q[`RCV_CTRL_PTR_LSB+1:`RCV_CTRL_PTR_LSB] = value_page_pointer;
    ctl_q[`RCV_CTRL_UNLOCK_BIT] = calendar_write_unlock;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_page_pointer <= `RCV_PTR_RST;
      calendar_write_unlock <= `RCV_UNLOCK_RST;
      rdata <= 16'h0000;
      rd_win_r <= 1'b0;
      rd_ctl_r <= 1'b0;
    end else if (ce) begin
      value_page_pointer <= ptr_nxt;
      if (ctl_wr) begin
        calendar_write_unlock <= wdata[`RCV_CTRL_UNLOCK_BIT];
      end
      rd_win_r <= win_rd;
      rd_ctl_r <= ctl_rd;
      if (win_rd) begin
        rdata <= page_clean(value_page_pointer, mem_view);
      end else if (ctl_rd) begin
        rdata <= ctl_q;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end
endmodule // rcv_value_window

//--- rcv_value_window_chk.sv
// Purpose: port assertions for the calendar value window
// Assumes: one clock, active-low asynchronous reset
// Notes: attached to rcv_value_window by bind
`timescale 1ns/10ps
module rcv_chk (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [1:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire [1:0] value_page_pointer,
  input wire calendar_write_unlock
);
  wire [1:0] pg = value_page_pointer;
  wire ul = calendar_write_unlock;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd;
    ce && rd && addr == 2'h0;
  endsequence
  sequence s_cw;
    ce && wr && addr == 2'h1;
  endsequence
  property p_dec; s_rd ##0 pg != 2'h0 |=> pg == $past(pg) - 2'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("pointer not decremented");
  property p_stop; s_rd ##0 pg == 2'h0 |=> pg == 2'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("pointer left zero");
  property p_hold; !(ce && (rd || wr)) |=> $stable(pg);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved idle");
  property p_yr; s_rd ##0 pg == 2'h3 |=> rdata[15:8] == 8'h0 &&
    rdata[7:4] <= 4'h9 && rdata[3:0] <= 4'h9; endproperty
  a_yr: assert property (p_yr) else $error("bad year page");
  property p_md; s_rd ##0 pg == 2'h2 |=> rdata[15:12] <= 4'h1 &&
    rdata[11:8] <= 4'h9 && rdata[7:4] <= 4'h3 && rdata[3:0] <= 4'h9;
  endproperty
  a_md: assert property (p_md) else $error("bad month page");
  property p_wh; s_rd ##0 pg == 2'h1 |=> rdata[15:11] == 5'h0 &&
    rdata[10:8] <= 3'h6 && rdata[7:4] <= 4'h2 && rdata[3:0] <= 4'h9;
  endproperty
  a_wh: assert property (p_wh) else $error("bad weekday page");
  property p_ctl; s_cw |=> pg == $past(wdata[9:8]) && ul == $past(wdata[0]);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control not taken");
  property p_ul; !(ce && wr && addr == 2'h1) |=> $stable(ul);
  endproperty
  a_ul: assert property (p_ul) else $error("unlock moved");
endmodule // rcv_chk
bind rcv_value_window rcv_chk chk_u (.clk, .rstn, .ce, .addr, .wdata, .wr,
  .rd, .rdata, .value_page_pointer, .calendar_write_unlock);

//--- tb.sv
// Purpose: self-checking bench for the calendar value window
// Assumes: ce held high, read data sampled one cycle after rd
// Notes: pages chosen through the control register
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  reg clk = 0, rstn = 0, ce = 1, wr = 0, rd = 0, year_step = 0;
  reg [1:0] addr = 2'h0, wbe = 2'h3;
  reg [15:0] wdata = 16'h0;
  reg [15:0] pv [0:3] = '{16'h0025, 16'h1231, 16'h0623, 16'h5959};
  wire [15:0] rdata;
  wire [1:0] pg;
  wire ul;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #25 clk = ~clk;
  rcv_value_window dut_u (.clk, .rstn, .ce, .addr, .wdata, .wbe, .wr,
    .rd, .year_step, .rdata, .value_page_pointer(pg),
    .calendar_write_unlock(ul));
  task wreg(input [1:0] a, input [15:0] d, input [1:0] be);
    addr <= a;
    wdata <= d;
    wbe <= be;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task rc(input [1:0] a, input [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) `CHK("rdata", e, rdata)
  endtask
  task sel(input [1:0] p);
    wreg(2'h1, {6'h0, p, 8'h01}, 2'h3);
  endtask
  task step;
    year_step <= 1'b1;
    @(posedge clk) year_step <= 1'b0;
    @(posedge clk);
  endtask
  task t_lock;
    rc(2'h1, 16'h0000);
    wreg(2'h1, 16'h0300, 2'h3);
    wreg(2'h0, 16'h0025, 2'h3);
    wreg(2'h1, 16'h0300, 2'h3);
    rc(2'h0, 16'h0000);
    $display("t_lock done");
  endtask
  task t_pages;
    sel(2'h3);
    for (int i = 0; i < 4; i++) wreg(2'h0, pv[i], 2'h3);
    rc(2'h1, 16'h0001);
    sel(2'h3);
    for (int i = 0; i < 4; i++) rc(2'h0, pv[i]);
    $display("t_pages done");
  endtask
  task t_part;
    sel(2'h3);
    wreg(2'h0, 16'hC099, 2'h1);
    rc(2'h1, 16'h0301);
    rc(2'h0, 16'h0099);
    sel(2'h2);
    wreg(2'h0, 16'hE0C9, 2'h3);
    sel(2'h2);
    rc(2'h0, 16'h0009);
    step;
    sel(2'h3);
    rc(2'h0, 16'h0000);
    sel(2'h3);
    wreg(2'h0, 16'h0019, 2'h3);
    step;
    sel(2'h3);
    rc(2'h0, 16'h0020);
    $display("t_part done");
  endtask
  task t_b2b;
    sel(2'h0);
    addr <= 2'h0;
    wdata <= 16'h0142;
    wbe <= 2'h3;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) `CHK("rdata", 16'h0142, rdata)
    $display("t_b2b done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_lock;
    t_pages;
    t_part;
    t_b2b;
    test_done;
  end
endmodule // tb
